// ### core/eepc_pkg.sv
// Shared constants for the serial memory control-word slave
package eepc_pkg;
  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;
  localparam int MEM_DEPTH = 512;
  localparam logic [3:0] SEL_PREFIX = 4'hA;
  localparam int SEL_PREFIX_MSB = 7;
  localparam int SEL_PREFIX_LSB = 4;
  localparam int SEL_TWO_POS = 3;
  localparam int SEL_ONE_POS = 2;
  localparam int SEL_PIN_POS = 1;
  localparam int SEL_RW_POS = 0;
  localparam logic SEL_TWO_EXPECT = 1'h0;
  localparam logic [3:0] CNT_LAST_BIT = 4'h7;
  localparam logic [3:0] CNT_ACK = 4'h8;
  localparam int CLK_MHZ = 250;
  localparam int PROG_TIME_US = 10000;
  localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
  typedef enum logic [2:0] {
    EEPC_IDLE = 3'b000,
    EEPC_SEL = 3'b001,
    EEPC_ADDR = 3'b010,
    EEPC_DATA = 3'b011,
    EEPC_READ = 3'b100,
    EEPC_IGNORE = 3'b101
  } eepc_state_t;
endpackage

// ### core/eepc_prog_timer.sv
// Self-timed programming cycle timer
`timescale 1ns/1ps
module eepc_prog_timer #(
  parameter int CYCLES = eepc_pkg::PROG_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic abort,
  output logic busy,
  output logic done
);
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic busy_reg;
  logic busy_next;
  logic done_reg;
  logic done_next;

  always_comb begin
    cnt_next = cnt_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    if (abort) begin
      busy_next = 1'b0;
    end else if (start) begin
      busy_next = 1'b1;
      cnt_next = 32'(CYCLES - 1);
    end else if (busy_reg) begin
      if (cnt_reg == 32'h0) begin
        busy_next = 1'b0;
        done_next = 1'b1;
      end else begin
        cnt_next = cnt_reg - 32'h1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt_reg <= 32'h0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
    end
  end

  assign busy = busy_reg;
  assign done = done_reg;
endmodule

// ### core/eepc_slave.sv
// Two-wire serial memory slave with self-timed programming
`timescale 1ns/1ps
// Behaviour
// R1: Write-select 1010,selects,0 is acknowledged on clock nine when selects match.
// R2: Read-select has a 1 in bit eight; acknowledged, then data shifts out.
// R3: Word address follows write-select, MSB first, acknowledged on clock nine.
// R4: Data byte after address is latched and acknowledged on clock nine.
// R5: Read data goes out MSB first; master acks low to continue, high ends.
// R6: Read-select gets no acknowledge while programming; acknowledged once done.
// R7: A write-select during programming aborts programming at once.
// R8: Sequential read increments address per master ack, wraps, releases at stop.
// R9: Programming starts only on stop after all 27 clocks of entry.
// R10: Floating select pin blocks programming; select bit must then be zero.
// R11: Unmatched selects release the line and ignore bytes until next start.
module eepc_slave #(
  parameter int PROG_CYCLES = eepc_pkg::PROG_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic sel_pin,
  input wire logic sel_float,
  output logic prog_busy
);
  logic [eepc_pkg::DATA_W-1:0] mem [eepc_pkg::MEM_DEPTH];
  eepc_pkg::eepc_state_t st_reg, st_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] sh_reg, sh_next;
  logic [eepc_pkg::ADDR_W-1:0] addr_reg, addr_next;
  logic [7:0] wdata_reg, wdata_next;
  logic full_reg, full_next;
  logic oe_n_reg, oe_n_next;
  logic scl_d, sda_d;
  logic prog_start, prog_abort, prog_done;
  logic scl_rise, scl_fall, start_c, stop_c, match;
  logic [7:0] rdata;

  function automatic logic sel_match(input logic [7:0] w, input logic pin, input logic flt);
    sel_match = (w[eepc_pkg::SEL_PREFIX_MSB:eepc_pkg::SEL_PREFIX_LSB] == eepc_pkg::SEL_PREFIX)
      && (w[eepc_pkg::SEL_TWO_POS] == eepc_pkg::SEL_TWO_EXPECT)
      && (w[eepc_pkg::SEL_PIN_POS] == (flt ? 1'b0 : pin)); // R10
  endfunction

  assign scl_rise = scl_in && !scl_d;
  assign scl_fall = !scl_in && scl_d;
  assign start_c = scl_in && scl_d && sda_d && !sda_in;
  assign stop_c = scl_in && scl_d && !sda_d && sda_in;
  assign match = sel_match(sh_reg, sel_pin, sel_float);
  assign rdata = mem[addr_reg];

  eepc_prog_timer #(.CYCLES(PROG_CYCLES)) u_timer (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .start(prog_start),
    .abort(prog_abort),
    .busy(prog_busy),
    .done(prog_done)
  );

  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    full_next = full_reg;
    oe_n_next = oe_n_reg;
    prog_start = 1'b0;
    prog_abort = 1'b0;
    if (start_c) begin
      st_next = eepc_pkg::EEPC_SEL;
      cnt_next = 4'hF; // Skip the fall that ends the start hold
      full_next = 1'b0;
      oe_n_next = 1'b1;
    end else if (stop_c) begin
      st_next = eepc_pkg::EEPC_IDLE;
      oe_n_next = 1'b1; // R8
      if (st_reg == eepc_pkg::EEPC_DATA && full_reg && cnt_reg == 4'h0 && !sel_float) begin
        prog_start = 1'b1; // R9 R10
      end
      full_next = 1'b0;
    end else if (st_reg != eepc_pkg::EEPC_IDLE && st_reg != eepc_pkg::EEPC_IGNORE) begin
      if (scl_rise && cnt_reg < eepc_pkg::CNT_ACK && st_reg != eepc_pkg::EEPC_READ) begin
        sh_next = {sh_reg[6:0], sda_in};
      end else if (scl_rise && cnt_reg == eepc_pkg::CNT_ACK && st_reg == eepc_pkg::EEPC_READ
          && full_reg) begin
        if (!sda_in) begin
          addr_next = addr_reg + 9'h001; // R8
        end else begin
          st_next = eepc_pkg::EEPC_IGNORE; // R5
        end
      end else if (scl_fall && cnt_reg == eepc_pkg::CNT_LAST_BIT) begin
        cnt_next = eepc_pkg::CNT_ACK;
        oe_n_next = 1'b1;
        unique case (st_reg)
          eepc_pkg::EEPC_SEL: begin
            if (!match) begin
              st_next = eepc_pkg::EEPC_IGNORE; // R11
            end else if (!sh_reg[eepc_pkg::SEL_RW_POS]) begin
              oe_n_next = 1'b0; // R1
              prog_abort = prog_busy; // R7
              addr_next[8] = sh_reg[eepc_pkg::SEL_ONE_POS];
              st_next = eepc_pkg::EEPC_ADDR;
            end else if (prog_busy) begin
              st_next = eepc_pkg::EEPC_IGNORE; // R6
            end else begin
              oe_n_next = 1'b0; // R2 R6
              st_next = eepc_pkg::EEPC_READ;
            end
          end
          eepc_pkg::EEPC_ADDR: begin
            oe_n_next = 1'b0; // R3
            addr_next[7:0] = sh_reg;
            st_next = eepc_pkg::EEPC_DATA;
          end
          eepc_pkg::EEPC_DATA: begin
            if (full_reg) begin
              full_next = 1'b0;
              st_next = eepc_pkg::EEPC_IGNORE;
            end else begin
              oe_n_next = 1'b0; // R4
              wdata_next = sh_reg;
              full_next = 1'b1;
            end
          end
          eepc_pkg::EEPC_READ: begin
            oe_n_next = 1'b1; // R5
          end
          default: begin
            st_next = eepc_pkg::EEPC_IGNORE;
          end
        endcase
      end else if (scl_fall && cnt_reg == eepc_pkg::CNT_ACK) begin
        cnt_next = 4'h0;
        oe_n_next = 1'b1;
        if (st_reg == eepc_pkg::EEPC_READ) begin
          sh_next = {rdata[6:0], 1'b1};
          full_next = 1'b1; // R8
          oe_n_next = rdata[7]; // R5
        end
      end else if (scl_fall) begin
        cnt_next = cnt_reg + 4'h1;
        if (st_reg == eepc_pkg::EEPC_READ) begin
          sh_next = {sh_reg[6:0], 1'b1};
          oe_n_next = sh_reg[7]; // R5
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_reg <= eepc_pkg::EEPC_IDLE;
      cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      addr_reg <= 9'h000;
      wdata_reg <= 8'hFF;
      full_reg <= 1'b0;
      oe_n_reg <= 1'b1;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      full_reg <= full_next;
      oe_n_reg <= oe_n_next;
      scl_d <= scl_in;
      sda_d <= sda_in;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (prog_done) begin
      mem[addr_reg] <= wdata_reg;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe_n = oe_n_reg;

  sequence s_sel_byte_end;
    scl_fall && !start_c && !stop_c && st_reg == eepc_pkg::EEPC_SEL && cnt_reg == 4'h7;
  endsequence

  property p_write_sel_ack;
    @(posedge ref_clk) disable iff (!rst_n)
      s_sel_byte_end and (match && !sh_reg[0]) |=> !sda_oe_n && st_reg == eepc_pkg::EEPC_ADDR;
  endproperty
  a_write_sel_ack: assert property (p_write_sel_ack) else $error("write select not acked"); // R1

  property p_read_sel_ack;
    @(posedge ref_clk) disable iff (!rst_n)
      s_sel_byte_end and (match && sh_reg[0] && !prog_busy) |=>
        !sda_oe_n && st_reg == eepc_pkg::EEPC_READ;
  endproperty
  a_read_sel_ack: assert property (p_read_sel_ack) else $error("read select not acked"); // R2

  property p_addr_latch;
    @(posedge ref_clk) disable iff (!rst_n)
      scl_fall && !start_c && !stop_c && st_reg == eepc_pkg::EEPC_ADDR && cnt_reg == 4'h7 |=>
        addr_reg[7:0] == $past(sh_reg) && !sda_oe_n;
  endproperty
  a_addr_latch: assert property (p_addr_latch) else $error("address not latched"); // R3

  property p_data_latch;
    @(posedge ref_clk) disable iff (!rst_n)
      scl_fall && !start_c && !stop_c && st_reg == eepc_pkg::EEPC_DATA && cnt_reg == 4'h7
        && !full_reg |=> wdata_reg == $past(sh_reg) && full_reg && !sda_oe_n;
  endproperty
  a_data_latch: assert property (p_data_latch) else $error("data not latched"); // R4

  property p_read_first_bit;
    @(posedge ref_clk) disable iff (!rst_n)
      scl_fall && !start_c && !stop_c && st_reg == eepc_pkg::EEPC_READ && cnt_reg == 4'h8 |=>
        sda_oe_n == $past(rdata[7]) && cnt_reg == 4'h0;
  endproperty
  a_read_first_bit: assert property (p_read_first_bit) else $error("read msb wrong"); // R5

  property p_poll_busy;
    @(posedge ref_clk) disable iff (!rst_n)
      s_sel_byte_end and (match && sh_reg[0] && prog_busy) |=>
        sda_oe_n && st_reg == eepc_pkg::EEPC_IGNORE;
  endproperty
  a_poll_busy: assert property (p_poll_busy) else $error("acked while busy"); // R6

  property p_abort;
    @(posedge ref_clk) disable iff (!rst_n)
      s_sel_byte_end and (match && !sh_reg[0] && prog_busy) |=> ##1 !prog_busy;
  endproperty
  a_abort: assert property (p_abort) else $error("programming not aborted"); // R7

  property p_read_incr;
    @(posedge ref_clk) disable iff (!rst_n)
      scl_rise && !start_c && !stop_c && st_reg == eepc_pkg::EEPC_READ && cnt_reg == 4'h8
        && full_reg && !sda_in |=> addr_reg == $past(addr_reg) + 9'h001;
  endproperty
  a_read_incr: assert property (p_read_incr) else $error("read address not advanced"); // R8

  property p_stop_release;
    @(posedge ref_clk) disable iff (!rst_n)
      stop_c |=> sda_oe_n && st_reg == eepc_pkg::EEPC_IDLE;
  endproperty
  a_stop_release: assert property (p_stop_release) else $error("line held after stop"); // R8

  property p_prog_start;
    @(posedge ref_clk) disable iff (!rst_n)
      stop_c && st_reg == eepc_pkg::EEPC_DATA && full_reg && cnt_reg == 4'h0 && !sel_float
        && !prog_busy |=> ##1 prog_busy;
  endproperty
  a_prog_start: assert property (p_prog_start) else $error("programming not started"); // R9

  property p_protect;
    @(posedge ref_clk) disable iff (!rst_n)
      sel_float && stop_c && !prog_busy |=> !prog_busy;
  endproperty
  a_protect: assert property (p_protect) else $error("programming while protected"); // R10

  property p_ignore_quiet;
    @(posedge ref_clk) disable iff (!rst_n)
      st_reg == eepc_pkg::EEPC_IGNORE && !start_c |=> sda_oe_n;
  endproperty
  a_ignore_quiet: assert property (p_ignore_quiet) else $error("drove while ignoring"); // R11
endmodule

// ### testbench/eepc_master.sv
// Behavioural two-wire bus master for the memory slave
`timescale 1ns/1ps
module eepc_master (
  input wire logic ref_clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic half();
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic start();
    sda <= 1'b1;
    scl <= 1'b1;
    half();
    sda <= 1'b0;
    half();
    scl <= 1'b0;
    half();
  endtask
  task automatic stop();
    sda <= 1'b0;
    half();
    scl <= 1'b1;
    half();
    sda <= 1'b1;
    half();
  endtask
  task automatic clk_bit(input logic b, output logic r);
    sda <= b;
    half();
    scl <= 1'b1;
    half();
    r = sda_line;
    scl <= 1'b0;
    @(posedge ref_clk);
  endtask
  // Byte MSB first, then ninth clock at the given level
  task automatic xfer(input logic [7:0] d, input logic lvl, output logic [7:0] q,
                      output logic ack);
    for (int i = 7; i >= 0; i--) begin
      clk_bit(d[i], q[i]);
    end
    clk_bit(lvl, ack);
  endtask
endmodule

// ### testbench/serial_eeprom_control_words_bench.sv
// Self-checking bench for the serial memory slave
`timescale 1ns/1ps
module serial_eeprom_control_words_bench;
  typedef struct {logic [8:0] a; logic [7:0] d;} eepc_row_t;
  logic ref_clk, rst_n, sel_pin, sel_float, scl, sda_m, sda_out, sda_oe_n, prog_busy;
  logic sda_line;
  logic [7:0] q;
  logic k;
  int num_errors = 0;
  int checks = 0;
  eepc_row_t rows [4] = '{'{9'h000, 8'h5A}, '{9'h1FF, 8'hA5}, '{9'h0FE, 8'h00},
                          '{9'h101, 8'hFF}};
  assign sda_line = sda_m & (sda_oe_n | sda_out);
  eepc_master i_mst (.ref_clk(ref_clk), .sda_line(sda_line), .scl(scl), .sda(sda_m));
  eepc_slave #(.PROG_CYCLES(400)) i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .scl_in(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .sel_pin(sel_pin),
    .sel_float(sel_float), .prog_busy(prog_busy));
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic chk1(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] sw(input logic [8:0] a, input logic pin, input logic rd);
    return {eepc_pkg::SEL_PREFIX, eepc_pkg::SEL_TWO_EXPECT, a[8], pin, rd};
  endfunction
  task automatic wr(input logic [8:0] a, input logic [7:0] d, input logic pin,
                    input logic exp);
    i_mst.start();
    i_mst.xfer(sw(a, pin, 1'b0), 1'b1, q, k);
    chk1(k, exp);
    i_mst.xfer(a[7:0], 1'b1, q, k);
    chk1(k, exp);
    i_mst.xfer(d, 1'b1, q, k);
    chk1(k, exp);
    i_mst.stop();
  endtask
  task automatic rd(input logic [8:0] a, input logic [7:0] e0, input logic [7:0] e1,
                    input int n);
    i_mst.start();
    i_mst.xfer(sw(a, sel_pin, 1'b0), 1'b1, q, k);
    i_mst.xfer(a[7:0], 1'b1, q, k);
    i_mst.start();
    i_mst.xfer(sw(a, sel_pin, 1'b1), 1'b1, q, k);
    chk1(k, 1'b0);
    for (int i = 0; i < n; i++) begin
      i_mst.xfer(8'hFF, i == n - 1, q, k);
      chk8(q, (i == 0) ? e0 : e1);
    end
    i_mst.stop();
  endtask
  task automatic poll();
    int n;
    n = 0;
    k = 1'b1;
    while (k !== 1'b0 && n < 20) begin
      i_mst.start();
      i_mst.xfer(sw(9'h000, sel_pin, 1'b1), 1'b1, q, k);
      if (n == 0) chk1(k, 1'b1);
      if (k !== 1'b0) i_mst.stop();
      n++;
    end
    chk1(k, 1'b0);
    chk1(prog_busy, 1'b0);
    i_mst.xfer(8'hFF, 1'b1, q, k);
    i_mst.stop();
  endtask
  task automatic tally_and_finish();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge ref_clk);
    num_errors++;
    tally_and_finish();
  end
  initial begin
    rst_n <= 1'b0;
    sel_pin <= 1'b1;
    sel_float <= 1'b0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    chk1(sda_oe_n, 1'b1);
    chk1(prog_busy, 1'b0);
    chk1(sda_out, 1'b0);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d, sel_pin, 1'b0);
      chk1(prog_busy, 1'b1);
      poll();
      rd(rows[i].a, rows[i].d, rows[i].d, 1);
    end
    rd(9'h1FF, 8'hA5, 8'h5A, 2);
    chk1(sda_oe_n, 1'b1);
    wr(9'h000, 8'h33, 1'b0, 1'b1);
    chk1(prog_busy, 1'b0);
    wr(9'h000, 8'h33, 1'b1, 1'b0);
    i_mst.start();
    i_mst.xfer(sw(9'h000, 1'b1, 1'b0), 1'b1, q, k);
    i_mst.xfer(8'h00, 1'b1, q, k);
    i_mst.stop();
    chk1(prog_busy, 1'b0);
    rd(9'h000, 8'h5A, 8'h5A, 1);
    sel_float <= 1'b1;
    wr(9'h002, 8'h77, 1'b1, 1'b1);
    wr(9'h002, 8'h77, 1'b0, 1'b0);
    chk1(prog_busy, 1'b0);
    sel_float <= 1'b0;
    tally_and_finish();
  end
endmodule
